// File: hw/capture_channel_group_irq.sv
// capture channel four with noise filter, edge select and group interrupt flags over apb
//
// How it works
// - edge select zero disables all capture
// - select rising, falling or both edges
// - filter off feeds raw pin to detector
// - filter on drops pulses under four clocks
// - control: filter bit7, edge bits1:0, rest zero
// - selected edge loads counter into capture register
// - capture register has no reset value
// - no capture load while software reads it
// - mask bits four to zero, one masks
// - mask bits seven to five read zero
// - status flags cleared by reading them
// - status bits seven to five read zero
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module capture_channel_group_irq #(
    parameter int COUNTER_WIDTH = 32,
    parameter int FILTER_CYCLES = capture_group_pkg::FILTER_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_input_pin,
    input wire logic [COUNTER_WIDTH-1:0] counter_value,
    input wire logic capture_event_five,
    input wire logic capture_event_six,
    input wire logic capture_event_seven,
    input wire logic timebase_interrupt,
    output logic irq
);

    initial begin
        if (COUNTER_WIDTH != 32) begin
            $error("capture register is exactly 32 bits wide");
        end
        if (FILTER_CYCLES < 2 || FILTER_CYCLES > 15) begin
            $error("filter length must lie in 2..15");
        end
    end

    function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] idx);
        addr_hit = (addr[31:2] == idx[29:0]) && (addr[1:0] == 2'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register bus decode

    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    capture_group_pkg::capture_ctrl_t ctrl_r;
    logic [4:0] flags_r;
    logic [4:0] mask_r;
    logic [31:0] cap_value_r;
    logic irq_r;

    wire sel_flags = addr_hit(paddr, capture_group_pkg::IDX_GROUP_EVENT_FLAGS);
    wire sel_mask = addr_hit(paddr, capture_group_pkg::IDX_GROUP_EVENT_MASK);
    wire sel_ctrl = addr_hit(paddr, capture_group_pkg::IDX_CAPTURE_CONTROL);
    wire sel_b3 = addr_hit(paddr, capture_group_pkg::IDX_CAPTURE_BYTE3);
    wire sel_b2 = addr_hit(paddr, capture_group_pkg::IDX_CAPTURE_BYTE2);
    wire sel_b1 = addr_hit(paddr, capture_group_pkg::IDX_CAPTURE_BYTE1);
    wire sel_b0 = addr_hit(paddr, capture_group_pkg::IDX_CAPTURE_BYTE0);
    wire sel_cap = sel_b3 | sel_b2 | sel_b1 | sel_b0;
    wire addr_ok = sel_flags | sel_mask | sel_ctrl | sel_cap;

    // one wait state: read data is registered on the same edge that pready rises
    wire access = psel & penable;
    wire access_first = access & ~pready_r;
    wire done = access & pready_r;
    wire wr_done = done & pwrite & ~pslverr_r;
    wire rd_done = done & ~pwrite & ~pslverr_r;

    wire [7:0] ctrl_rd = {ctrl_r.filter_en, 5'h00, ctrl_r.edge_sel};
    wire [7:0] flags_rd = {3'h0, flags_r};
    wire [7:0] mask_rd = {3'h0, mask_r};

    wire [7:0] rd_byte = sel_flags ? flags_rd :
                         sel_mask ? mask_rd :
                         sel_ctrl ? ctrl_rd :
                         sel_b3 ? cap_value_r[31:24] :
                         sel_b2 ? cap_value_r[23:16] :
                         sel_b1 ? cap_value_r[15:8] :
                         sel_b0 ? cap_value_r[7:0] : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else if (access_first) begin
            pready_r <= 1'b1;
            pslverr_r <= ~addr_ok;
            prdata_r <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////////
    // control and mask registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= capture_group_pkg::CTRL_RESET;
        end else if (wr_done && sel_ctrl) begin
            ctrl_r.filter_en <= pwdata[capture_group_pkg::CTRL_FILTER_BIT];
            ctrl_r.unused <= 5'h00;
            ctrl_r.edge_sel <= pwdata[capture_group_pkg::CTRL_EDGE_MSB:capture_group_pkg::CTRL_EDGE_LSB];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= capture_group_pkg::MASK_RESET;
        end else if (wr_done && sel_mask) begin
            mask_r <= pwdata[capture_group_pkg::FLAG_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // noise filter and edge detection

    logic filt_r;
    logic [3:0] filt_cnt_r;
    logic lvl_prev_r;

    wire pin_differs = capture_input_pin ^ filt_r;
    wire filt_flip = pin_differs && (filt_cnt_r == 4'(FILTER_CYCLES - 1));

    // level must hold for the full filter length before it is accepted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_r <= 1'b0;
            filt_cnt_r <= 4'h0;
        end else if (!pin_differs || filt_flip) begin
            filt_r <= filt_flip ? capture_input_pin : filt_r;
            filt_cnt_r <= 4'h0;
        end else begin
            filt_cnt_r <= filt_cnt_r + 4'h1;
        end
    end

    // raw pin when filter is off
    wire trig_level = ctrl_r.filter_en ? filt_r : capture_input_pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_prev_r <= 1'b0;
        end else begin
            lvl_prev_r <= trig_level;
        end
    end

    wire rise = trig_level & ~lvl_prev_r;
    wire fall = ~trig_level & lvl_prev_r;

    wire trigger = ((ctrl_r.edge_sel == capture_group_pkg::EDGE_RISE) & rise) |
                   ((ctrl_r.edge_sel == capture_group_pkg::EDGE_FALL) & fall) |
                   ((ctrl_r.edge_sel == capture_group_pkg::EDGE_BOTH) & (rise | fall));

    ////////////////////////////////////////////////////////////////////////////
    // capture register

    // hold the value from setup to completion of any capture byte read
    wire suppress = psel & ~pwrite & sel_cap;
    wire cap_load = trigger & ~suppress;

    // no reset: content is undefined until the first capture
    // latch counter on the chosen edge
    always_ff @(posedge pclk) begin
        if (cap_load) begin
            cap_value_r <= counter_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // group flags and interrupt

    // a trigger that lands in a read window still flags, only the load is held off
    wire [4:0] flag_set = {timebase_interrupt, capture_event_seven, capture_event_six, capture_event_five, trigger};
    // only the bits actually returned are cleared, so an event after sampling survives
    wire [4:0] flag_clr = (rd_done && sel_flags) ? prdata_r[4:0] :
                          (wr_done && sel_flags) ? pwdata[4:0] : 5'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= capture_group_pkg::FLAGS_RESET;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(flags_r & ~mask_r);
        end
    end

    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    a_off_no_load: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == capture_group_pkg::EDGE_NONE) && (rise || fall) |=> $stable(cap_value_r))
        else $error("capture register changed with capture disabled");

    a_rise_loads: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == capture_group_pkg::EDGE_RISE) && rise && !suppress
        |=> cap_value_r == $past(counter_value))
        else $error("rising edge did not load counter");

    a_fall_loads: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == capture_group_pkg::EDGE_FALL) && fall && !suppress
        |=> cap_value_r == $past(counter_value))
        else $error("falling edge did not load counter");

    a_rise_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == capture_group_pkg::EDGE_FALL) && rise |-> !trigger)
        else $error("rising edge triggered in falling mode");

    a_raw_path: assert property (@(posedge pclk) disable iff (!presetn)
        $past(!ctrl_r.filter_en) && !ctrl_r.filter_en && $rose(capture_input_pin)
        && (ctrl_r.edge_sel == capture_group_pkg::EDGE_BOTH) && !suppress
        |=> cap_value_r == $past(counter_value))
        else $error("raw input edge not captured");

    a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(filt_r) |-> $past(capture_input_pin, 1) && $past(capture_input_pin, 2)
        && $past(capture_input_pin, 3) && $past(capture_input_pin, 4))
        else $error("filter accepted a short high pulse");

    a_read_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        suppress |=> $stable(cap_value_r))
        else $error("capture register loaded during a read");

    a_ctrl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pready_r) && !pwrite && sel_ctrl |-> prdata_r[6:2] == 5'h00 && prdata_r[31:8] == 24'h000000)
        else $error("unused control bits read nonzero");

    a_group_zero: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pready_r) && !pwrite && (sel_flags || sel_mask) |-> prdata_r[7:5] == 3'h0)
        else $error("unused group bits read nonzero");

    a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && sel_flags |=> (flags_r & $past(prdata_r[4:0]) & ~$past(flag_set)) == 5'h00)
        else $error("status read did not clear returned flags");

    a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
        |(flags_r & ~mask_r) |=> irq ##0 (flags_r != 5'h00 || $past(flag_clr) != 5'h00))
        else $error("unmasked flag failed to raise interrupt");

    a_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_r & ~mask_r) == 5'h00 |=> !irq)
        else $error("interrupt raised while all flags masked");

    // edge decode checked per mode, so a swapped select code shows at once
    a_none_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == capture_group_pkg::EDGE_NONE) |-> !trigger)
        else $error("trigger seen with capture disabled");

    a_fall_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == capture_group_pkg::EDGE_RISE) && fall |-> !trigger)
        else $error("falling edge triggered in rising mode");

    a_both_edges: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == capture_group_pkg::EDGE_BOTH) && (rise || fall) |-> trigger)
        else $error("edge missed in both-edge mode");

    a_rise_triggers: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == capture_group_pkg::EDGE_RISE) && rise |-> trigger)
        else $error("rising edge missed in rising mode");

    a_fall_triggers: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == capture_group_pkg::EDGE_FALL) && fall |-> trigger)
        else $error("falling edge missed in falling mode");

    a_raw_fall: assert property (@(posedge pclk) disable iff (!presetn)
        $past(!ctrl_r.filter_en) && !ctrl_r.filter_en && $fell(capture_input_pin)
        && (ctrl_r.edge_sel == capture_group_pkg::EDGE_BOTH) && !suppress
        |=> cap_value_r == $past(counter_value))
        else $error("raw falling edge not captured");

    a_raw_level: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_r.filter_en |-> trig_level == capture_input_pin)
        else $error("raw path does not follow the pin");

    a_filter_low: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(filt_r) |-> !$past(capture_input_pin, 1) && !$past(capture_input_pin, 2)
        && !$past(capture_input_pin, 3) && !$past(capture_input_pin, 4))
        else $error("filter accepted a short low pulse");

    a_filter_level: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.filter_en |-> trig_level == filt_r)
        else $error("filtered path bypassed");

    a_filter_count: assert property (@(posedge pclk) disable iff (!presetn)
        filt_cnt_r < 4'(FILTER_CYCLES))
        else $error("filter counter ran past its length");

    a_ctrl_unused: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.unused == 5'h00)
        else $error("unused control bits hold a one");

    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && sel_ctrl |=> ctrl_r.edge_sel == $past(pwdata[1:0])
        && ctrl_r.filter_en == $past(pwdata[capture_group_pkg::CTRL_FILTER_BIT]))
        else $error("control write did not land");

    a_cap_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && sel_cap && !cap_load |=> $stable(cap_value_r))
        else $error("write changed the read-only capture register");

    a_both_loads: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r.edge_sel == capture_group_pkg::EDGE_BOTH) && (rise || fall) && !suppress
        |=> cap_value_r == $past(counter_value))
        else $error("edge did not load counter in both-edge mode");

    a_read_no_load: assert property (@(posedge pclk) disable iff (!presetn)
        suppress |-> !cap_load)
        else $error("load enabled during a capture read");

    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && sel_mask |=> mask_r == $past(pwdata[4:0]))
        else $error("mask write did not land");

    a_mask_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pready_r) && !pwrite && sel_mask |-> prdata_r[7:5] == 3'h0)
        else $error("unused mask bits read nonzero");

    a_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
        flag_clr == 5'h00 && flag_set == 5'h00 |=> $stable(flags_r))
        else $error("status flags changed with no event or clear");

    a_tb_flag: assert property (@(posedge pclk) disable iff (!presetn)
        timebase_interrupt |=> flags_r[capture_group_pkg::FLAG_TIMEBASE_BIT])
        else $error("time-base event did not set its flag");

    a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pready_r) && !pwrite |-> prdata_r[31:8] == 24'h000000)
        else $error("read data above bit seven nonzero");

    a_cap_flag: assert property (@(posedge pclk) disable iff (!presetn)
        trigger |=> flags_r[capture_group_pkg::FLAG_CAP4_BIT])
        else $error("capture event did not set its flag");

    a_ev_flags: assert property (@(posedge pclk) disable iff (!presetn)
        (capture_event_five || capture_event_six || capture_event_seven)
        |=> (flags_r[3:1] & $past({capture_event_seven, capture_event_six, capture_event_five}))
        == $past({capture_event_seven, capture_event_six, capture_event_five}))
        else $error("group event did not set its flag");

endmodule // capture_channel_group_irq

// File: hw/capture_group_pkg.sv
// constants and types shared by the capture channel and its group interrupt logic
package capture_group_pkg;

    // register indexes; byte address on the bus is four times the index
    localparam logic [31:0] IDX_GROUP_EVENT_FLAGS = 32'hFFFFF408;
    localparam logic [31:0] IDX_GROUP_EVENT_MASK = 32'hFFFFF409;
    localparam logic [31:0] IDX_CAPTURE_CONTROL = 32'hFFFFF433;
    localparam logic [31:0] IDX_CAPTURE_BYTE3 = 32'hFFFFF434;
    localparam logic [31:0] IDX_CAPTURE_BYTE2 = 32'hFFFFF435;
    localparam logic [31:0] IDX_CAPTURE_BYTE1 = 32'hFFFFF436;
    localparam logic [31:0] IDX_CAPTURE_BYTE0 = 32'hFFFFF437;

    // capture control field positions
    localparam int CTRL_FILTER_BIT = 7;
    localparam int CTRL_EDGE_LSB = 0;
    localparam int CTRL_EDGE_MSB = 1;

    // group flag and mask bit positions
    localparam int FLAG_CAP4_BIT = 0;
    localparam int FLAG_CAP5_BIT = 1;
    localparam int FLAG_CAP6_BIT = 2;
    localparam int FLAG_CAP7_BIT = 3;
    localparam int FLAG_TIMEBASE_BIT = 4;
    localparam int FLAG_WIDTH = 5;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [4:0] MASK_RESET = 5'h00;

    // edge select encodings
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // noise filter: pulses shorter than this many system clock periods are dropped
    localparam int CLK_PERIOD_NS = 40;
    localparam int FILTER_PERIODS = 4;
    localparam int FILTER_CYCLES = FILTER_PERIODS;

    typedef struct packed {
        logic filter_en;
        logic [4:0] unused;
        logic [1:0] edge_sel;
    } capture_ctrl_t;

    typedef struct packed {
        logic timebase;
        logic cap7;
        logic cap6;
        logic cap5;
        logic cap4;
    } group_flags_t;

endpackage

// File: tb/pin_driver.sv
// partner model: external source that drives the capture input pin
`timescale 1ns/1ns
module pin_driver (
    input wire logic pclk,
    output logic pin
);
    initial pin = 1'b0;
    // levels change only just after an edge, as the pin is sampled synchronously
    task automatic pulse(input int width);
        pin <= 1'b1;
        repeat (width) @(posedge pclk);
        pin <= 1'b0;
        @(posedge pclk);
    endtask
endmodule // pin_driver

// File: tb/capture_channel_group_irq_tb.sv
// self-checking bench for the capture channel and its group interrupt flags
`timescale 1ns/1ns
module capture_channel_group_irq_tb;
    localparam logic [31:0] A_FLG = capture_group_pkg::IDX_GROUP_EVENT_FLAGS << 2;
    localparam logic [31:0] A_MASK = capture_group_pkg::IDX_GROUP_EVENT_MASK << 2;
    localparam logic [31:0] A_CTRL = capture_group_pkg::IDX_CAPTURE_CONTROL << 2;
    localparam logic [31:0] A_B3 = capture_group_pkg::IDX_CAPTURE_BYTE3 << 2;
    localparam int FP = capture_group_pkg::FILTER_PERIODS;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, pin, ev5, ev6, ev7, tbi, fmode, prev, e;
    logic [31:0] paddr, pwdata, prdata, cnt, q, exp_cap;
    logic [7:0] exp_ctrl, exp_mask, exp_flags;
    int fails, samples_checked;
    int modes[4] = '{1, 2, 3, 0};
    capture_channel_group_irq DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(pin), .counter_value(cnt), .capture_event_five(ev5), .capture_event_six(ev6),
        .capture_event_seven(ev7), .timebase_interrupt(tbi), .irq(irq));
    pin_driver drv (.pclk(pclk), .pin(pin));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) cnt <= cnt + 32'h1;
    ////////////////////////////////////////////////////////////////
    // raw capture model
    always @(posedge pclk) begin
        if (!fmode && pin !== prev && (pin ? exp_ctrl[0] : exp_ctrl[1])) begin
            exp_flags[0] = 1'b1;
            if (!(psel && !pwrite && paddr[31:4] == 28'hFFFFD0D)) exp_cap = cnt;
        end
        prev = pin;
    end
    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        int n;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
        if (a == A_CTRL) exp_ctrl = d[7:0] & 8'h83;
        if (a == A_MASK) exp_mask = d[7:0] & 8'h1F;
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] ex);
        apb(1'b0, a, 32'h0, q, e);
        chk("read data", {24'h0, ex}, q);
        chk("pslverr", 32'h0, {31'h0, e});
        if (a == A_FLG) exp_flags = 8'h00;
    endtask
    task automatic rd_cap();
        for (int i = 0; i < 4; i++) rd(A_B3 + 32'(4 * i), exp_cap[31 - 8 * i -: 8]);
    endtask
    task automatic chk_irq();
        repeat (3) @(posedge pclk);
        chk("irq", {31'h0, |(exp_flags[4:0] & ~exp_mask[4:0])}, {31'h0, irq});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(75026));
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
        {tbi, ev7, ev6, ev5} = 4'h0;
        fmode = 1'b0; prev = 1'b0; exp_ctrl = 8'h00; exp_mask = 8'h00; exp_flags = 8'h00; exp_cap = 'x;
        cnt = $urandom; fails = 0; samples_checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(A_FLG, 8'h00);
        rd(A_MASK, 8'h00);
        rd(A_CTRL, 8'h00);
        wr(A_CTRL, 32'hFFFFFFFF);
        rd(A_CTRL, exp_ctrl);
        wr(A_MASK, 32'hFFFFFFFF);
        rd(A_MASK, exp_mask);
        wr(A_MASK, 32'h0);
        foreach (modes[i]) begin
            wr(A_CTRL, 32'(modes[i]));
            drv.pulse(2 + $urandom % 5);
            chk_irq();
            rd(A_FLG, exp_flags);
            rd_cap();
        end
        wr(A_CTRL, 32'h1);
        fork
            rd(A_B3 + 32'hC, exp_cap[7:0]);
            begin
                @(posedge pclk);
                drv.pulse(2);
            end
        join
        rd_cap();
        rd(A_FLG, exp_flags);
        wr(A_B3, 32'hFF);
        rd_cap();
        apb(1'b0, 32'hFFFFD000, 32'h0, q, e);
        chk("unmapped pslverr", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        fmode = 1'b1;
        wr(A_CTRL, 32'h81);
        drv.pulse(FP - 1);
        repeat (8) @(posedge pclk);
        rd(A_FLG, 8'h00);
        drv.pulse(FP + 2);
        repeat (8) @(posedge pclk);
        rd(A_FLG, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(A_MASK, $urandom);
            {tbi, ev7, ev6, ev5} <= 4'($urandom);
            @(posedge pclk);
            exp_flags[4:1] = {tbi, ev7, ev6, ev5};
            {tbi, ev7, ev6, ev5} <= 4'h0;
            chk_irq();
            rd(A_FLG, exp_flags);
            chk_irq();
        end
        end_sim();
    end
endmodule // capture_channel_group_irq_tb
